// [common/tec_pkg.sv]
/*
 * Package for the 8-bit timer/event counter: register offsets, control
 * field positions, reset values, mode and state encodings, carrier type.
 * Assumes an APB slave with 32-bit data and byte addresses on 8 bits.
 */
package tec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int unsigned ADDR_W = 8; // APB address width
    localparam int unsigned DATA_W = 32; // APB data width
    localparam int unsigned CNT_W = 8; // Counter width
    localparam int unsigned PSC_W = 3; // Prescale rate field width
    localparam int unsigned PRE_W = 7; // Prescaler counter width

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_COUNT = 8'h00; // Count / preload
    localparam logic [7:0] OFF_CTRL = 8'h04; // Timer control
    localparam logic [7:0] OFF_INTCTL = 8'h08; // Interrupt control

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTRL_PSC_LSB = 0; // Prescale rate bits 0..2
    localparam int unsigned CTRL_EDGE_BIT = 3; // Edge select bit
    localparam int unsigned CTRL_RUN_BIT = 4; // Run enable bit
    localparam int unsigned CTRL_MODE_LSB = 6; // Mode field bits 7..6
    localparam int unsigned INTCTL_EN_BIT = 0; // Overflow interrupt enable

    ////////////////////////////////////////////////////////////////////////
    // Reset values and constants
    localparam logic [7:0] CTRL_RST = 8'h00; // Control after reset
    localparam logic INTCTL_RST = 1'b0; // Interrupt enable after reset
    localparam logic [7:0] COUNT_RST = 8'h00; // Counter after reset
    localparam logic [7:0] COUNT_FULL = 8'hFF; // Last value before overflow
    localparam logic [7:0] COUNT_ONE = 8'h01; // Increment step
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000; // Idle read data

    ////////////////////////////////////////////////////////////////////////
    // Mode field encoding
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00, // Counter idle
        MODE_EVENT = 2'b01, // External event counting
        MODE_TIMER = 2'b10, // Internal timer
        MODE_PULSE = 2'b11 // Pulse width measurement
    } tec_mode_t;

    // Pulse width measurement states, one-hot
    typedef enum logic [2:0] {
        PW_IDLE = 3'b001, // Not armed
        PW_WAIT = 3'b010, // Armed, waiting for active edge
        PW_MEAS = 3'b100 // Measuring
    } tec_pw_state_t;

    // Control register carrier, bit 7 down to bit 0
    typedef struct packed {
        tec_mode_t mode; // Bits 7..6
        logic rsv; // Bit 5, reads zero
        logic run; // Bit 4
        logic edge_sel; // Bit 3
        logic [2:0] psc; // Bits 2..0
    } tec_ctrl_t;

endpackage : tec_pkg

// [design/tec_prescaler.sv]
/*
 * Prescaler for the timer: a free-running divider of core_clk giving a
 * one-cycle enable every 2^rate cycles (rate 0 gives every cycle).
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module tec_prescaler (
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [tec_pkg::PSC_W-1:0] rate, // Division rate select
    output logic tick_q // One-cycle count enable
);

    ////////////////////////////////////////////////////////////////////////
    // Mask of low divider bits that must all be set for a tick
    function automatic logic [tec_pkg::PRE_W-1:0] rate_mask(
        input logic [tec_pkg::PSC_W-1:0] r
    );
        logic [tec_pkg::PRE_W:0] one_hot;
        one_hot = '0;
        one_hot[r] = 1'b1;
        rate_mask = tec_pkg::PRE_W'(one_hot - 1'b1);
    endfunction : rate_mask

    logic [tec_pkg::PRE_W-1:0] div_q; // Free-running divider
    logic [tec_pkg::PRE_W-1:0] mask; // Current mask

    assign mask = rate_mask(rate);

    ////////////////////////////////////////////////////////////////////////
    // Divider counter
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            div_q <= '0;
        end else begin
            div_q <= tec_pkg::PRE_W'(div_q + 1'b1);
        end
    end

    // Tick when the masked low bits are all ones
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= ((div_q & mask) == mask);
        end
    end

endmodule : tec_prescaler

// [design/tec_top.sv]
/*
 * 8-bit count-up timer/event counter with preload, control and interrupt
 * control registers on APB, timer pin input, overflow request output.
 * Assumes APB master timing, a timer pin synchronous-agnostic input that
 * is resynchronised here, and one 20 MHz clock with synchronous reset.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - One 8-bit up counter, three modes
// - Count read returns live counter value
// - Timer, pulse modes use prescaled internal clock
// - Event mode counts selected pin edges
// - Overflow after FFh: request, reload, continue
// - Preload has no reset value
// - Preload write while stopped also loads counter
// - Preload write while running waits overflow
// - Mode field sits in control bits 7..6
// - Control bit 4 runs or halts counter
// - Prescaler ignored in event counting mode
// - Control bit 3 selects pin edge polarity
// - Timer mode adds one per prescaled tick
// - Overflow request only when enable set
// - Event edge: zero rising, one falling
// - Pulse mode: measure, then auto-clear run
// - Event counting continues in power-down, wakes
module tec_top (
    input wire logic core_clk, // 20 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [tec_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [tec_pkg::DATA_W-1:0] pwdata, // APB write data
    output logic [tec_pkg::DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic tmr_pin, // Timer pin level
    input wire logic power_down, // Core in power-down
    output logic ovf_irq, // Overflow interrupt request pulse
    output logic wake_req // Wake-up request pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    tec_pkg::tec_ctrl_t ctrl_q; // Timer control register
    logic int_en_q; // Overflow interrupt enable
    logic [tec_pkg::CNT_W-1:0] count_q; // Running counter
    logic [tec_pkg::CNT_W-1:0] preload_q; // Preload register, no reset
    tec_pkg::tec_pw_state_t pw_q; // Pulse measurement state
    tec_pkg::tec_pw_state_t pw_d; // Its next value
    logic pin_meta_q; // Synchroniser first stage
    logic pin_sync_q; // Synchroniser second stage
    logic pin_prev_q; // Previous synchronised level
    logic pin_rise; // Rising edge seen
    logic pin_fall; // Falling edge seen
    logic ev_edge; // Active edge in event mode
    logic pw_start; // Start edge in pulse mode
    logic pw_end; // End edge in pulse mode
    logic pw_done; // Pulse finished, clear run
    logic tick; // Prescaled enable
    logic running; // Counter enabled in a live mode
    logic inc; // Counter advances this cycle
    logic ovf; // Counter overflows this cycle
    logic setup; // APB setup phase
    logic access; // APB access completing
    logic wr_count; // Write to count register
    logic wr_ctrl; // Write to control register
    logic wr_intctl; // Write to interrupt control
    logic mapped; // Address hits a register

    ////////////////////////////////////////////////////////////////////////
    // Mode decode used in several places
    function automatic logic in_mode(
        input tec_pkg::tec_ctrl_t c,
        input tec_pkg::tec_mode_t m
    );
        in_mode = (c.mode == m);
    endfunction : in_mode

    // Register hit decode on the word address
    function automatic logic hit(
        input logic [tec_pkg::ADDR_W-1:0] a,
        input logic [7:0] off
    );
        hit = (a[tec_pkg::ADDR_W-1:2] == off[tec_pkg::ADDR_W-1:2]);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Timer pin synchroniser and edge detect
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= tmr_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Edges from the second stage only
    assign pin_rise = pin_sync_q & ~pin_prev_q;
    assign pin_fall = ~pin_sync_q & pin_prev_q;
    // Event edge: low counts rising, high counts falling
    assign ev_edge = ctrl_q.edge_sel ? pin_fall : pin_rise;
    // Pulse start is the opposite transition, end returns to idle level
    assign pw_start = ctrl_q.edge_sel ? pin_rise : pin_fall;
    assign pw_end = ctrl_q.edge_sel ? pin_fall : pin_rise;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    tec_prescaler u_psc (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .rate(ctrl_q.psc),
        .tick_q(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign mapped = hit(paddr, tec_pkg::OFF_COUNT) | hit(paddr, tec_pkg::OFF_CTRL)
                  | hit(paddr, tec_pkg::OFF_INTCTL);
    assign wr_count = access & pwrite & hit(paddr, tec_pkg::OFF_COUNT);
    assign wr_ctrl = access & pwrite & hit(paddr, tec_pkg::OFF_CTRL);
    assign wr_intctl = access & pwrite & hit(paddr, tec_pkg::OFF_INTCTL);

    // Ready for the access phase that follows each setup
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Error flagged for an unmapped address
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & ~mapped;
        end
    end

    // Read data captured at the setup edge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prdata <= tec_pkg::DATA_ZERO;
        end else if (setup && !pwrite) begin
            if (hit(paddr, tec_pkg::OFF_COUNT)) begin
                prdata <= {24'h00_0000, count_q};
            end else if (hit(paddr, tec_pkg::OFF_CTRL)) begin
                prdata <= {24'h00_0000, ctrl_q};
            end else if (hit(paddr, tec_pkg::OFF_INTCTL)) begin
                prdata <= {31'h0000_0000, int_en_q};
            end else begin
                prdata <= tec_pkg::DATA_ZERO;
            end
        end else begin
            prdata <= tec_pkg::DATA_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, run bit cleared when a pulse ends
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_q <= tec_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
            ctrl_q.rsv <= 1'b0;
        end else if (pw_done) begin
            ctrl_q.run <= 1'b0;
        end
    end

    // Interrupt control register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            int_en_q <= tec_pkg::INTCTL_RST;
        end else if (wr_intctl) begin
            int_en_q <= pwdata[tec_pkg::INTCTL_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse width measurement sequencer
    always_comb begin
        pw_d = pw_q;
        unique case (pw_q)
            tec_pkg::PW_IDLE: begin
                if (in_mode(ctrl_q, tec_pkg::MODE_PULSE) && ctrl_q.run) begin
                    pw_d = tec_pkg::PW_WAIT;
                end
            end
            tec_pkg::PW_WAIT: begin
                if (!in_mode(ctrl_q, tec_pkg::MODE_PULSE) || !ctrl_q.run) begin
                    pw_d = tec_pkg::PW_IDLE;
                end else if (pw_start) begin
                    pw_d = tec_pkg::PW_MEAS;
                end
            end
            tec_pkg::PW_MEAS: begin
                if (!in_mode(ctrl_q, tec_pkg::MODE_PULSE) || !ctrl_q.run || pw_end) begin
                    pw_d = tec_pkg::PW_IDLE;
                end
            end
            default: begin
                pw_d = tec_pkg::PW_IDLE;
            end
        endcase
    end

    // Pulse state register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pw_q <= tec_pkg::PW_IDLE;
        end else begin
            pw_q <= pw_d;
        end
    end

    // End of pulse while measuring in pulse mode
    assign pw_done = (pw_q == tec_pkg::PW_MEAS) && pw_end && ctrl_q.run
                   && in_mode(ctrl_q, tec_pkg::MODE_PULSE);

    ////////////////////////////////////////////////////////////////////////
    // Count enable per mode; idle code never counts
    assign running = ctrl_q.run && !in_mode(ctrl_q, tec_pkg::MODE_IDLE);
    assign inc = running && (
        (in_mode(ctrl_q, tec_pkg::MODE_TIMER) && tick)
        || (in_mode(ctrl_q, tec_pkg::MODE_EVENT) && ev_edge)
        || (in_mode(ctrl_q, tec_pkg::MODE_PULSE) && (pw_q == tec_pkg::PW_MEAS) && tick));
    assign ovf = inc && (count_q == tec_pkg::COUNT_FULL);

    // Preload register, left without reset
    always_ff @(posedge core_clk) begin
        if (wr_count) begin
            preload_q <= pwdata[7:0];
        end
    end

    // Counter: direct load when stopped, else count and reload
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            count_q <= tec_pkg::COUNT_RST;
        end else if (wr_count && !running) begin
            count_q <= pwdata[7:0];
        end else if (ovf) begin
            count_q <= preload_q;
        end else if (inc) begin
            count_q <= tec_pkg::CNT_W'(count_q + tec_pkg::COUNT_ONE);
        end
    end

    // Overflow request, gated by interrupt enable
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ovf_irq <= 1'b0;
        end else begin
            ovf_irq <= ovf && int_en_q;
        end
    end

    // Wake-up from event-mode overflow while powered down
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= ovf && int_en_q && power_down
                      && in_mode(ctrl_q, tec_pkg::MODE_EVENT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Pulse ends while measuring
    sequence pw_measuring_s;
        (pw_q == tec_pkg::PW_MEAS) && ctrl_q.run && in_mode(ctrl_q, tec_pkg::MODE_PULSE);
    endsequence
    sequence pw_finish_s;
        pw_measuring_s ##0 (pw_end && !wr_ctrl);
    endsequence

    ovf_reload_a: assert property (
        (ovf && !(wr_count && !running)) |=> (count_q == $past(preload_q)))
        else $error("counter did not reload preload on overflow");
    timer_step_a: assert property (
        (inc && !ovf && !(wr_count && !running)) |=> (count_q == $past(count_q) + 8'h01))
        else $error("counter did not step by one");
    halt_hold_a: assert property (
        (!ctrl_q.run && !wr_count) |=> $stable(count_q))
        else $error("stopped counter changed");
    stopped_load_a: assert property (
        (wr_count && !running) |=> (count_q == $past(pwdata[7:0])))
        else $error("stopped write did not load counter");
    running_write_a: assert property (
        (wr_count && running && !inc) |=> $stable(count_q) && (preload_q == $past(pwdata[7:0])))
        else $error("running write disturbed counter");
    irq_gate_a: assert property (
        ovf_irq |-> $past(ovf) && $past(int_en_q))
        else $error("overflow request without enable");
    event_no_psc_a: assert property (
        (running && in_mode(ctrl_q, tec_pkg::MODE_EVENT) && !ev_edge && !wr_count)
        |=> $stable(count_q))
        else $error("event counter moved without pin edge");
    pulse_stop_a: assert property (
        pw_finish_s |=> !ctrl_q.run ##1 (pw_q == tec_pkg::PW_IDLE))
        else $error("pulse end did not clear run");
    idle_mode_a: assert property (
        (in_mode(ctrl_q, tec_pkg::MODE_IDLE) && !wr_count) |=> $stable(count_q))
        else $error("idle mode counted");
    pin_sync_a: assert property (
        ##2 (pin_sync_q == $past(tmr_pin, 2)))
        else $error("timer pin synchroniser latency wrong");

    // Pulse counter waits for the start edge before moving
    pulse_wait_a: assert property (
        (pw_q == tec_pkg::PW_WAIT && !wr_count) |=> $stable(count_q))
        else $error("pulse counter moved before start edge");

    // Count read returns the counter value at the setup edge
    read_live_a: assert property (
        (setup && !pwrite && hit(paddr, tec_pkg::OFF_COUNT))
        |=> (prdata[7:0] == $past(count_q)))
        else $error("count read did not return live counter");

    // Enabled overflow always raises the request
    irq_fire_a: assert property (
        (ovf && int_en_q) |=> ovf_irq)
        else $error("enabled overflow gave no request");

    // Wake only from an event-mode overflow in power-down
    wake_fire_a: assert property (
        (ovf && int_en_q && power_down && in_mode(ctrl_q, tec_pkg::MODE_EVENT))
        |=> wake_req)
        else $error("event overflow in power-down did not wake");
    wake_gate_a: assert property (
        wake_req |-> $past(power_down) && $past(in_mode(ctrl_q, tec_pkg::MODE_EVENT)))
        else $error("wake request outside event power-down");

endmodule : tec_top

// [tb/tec_pin_src.sv]
/*
 * Far-side model of the timer pin: holds an idle level, then makes a
 * number of toggles spaced a given number of core_clk cycles apart.
 * Assumes requests come as a one-cycle go pulse while not busy.
 */
`timescale 1ns/1ps

module tec_pin_src (
    input wire logic core_clk, // System clock
    input wire logic go, // Start request, one cycle
    input wire logic idle_lvl, // Level held before the toggles
    input wire logic [7:0] n_tog, // Number of pin transitions
    input wire logic [7:0] gap, // Cycles between transitions
    output logic tmr_pin, // Timer pin level
    output logic busy // High while a pattern runs
);
    logic lvl; // Current level being driven

    ////////////////////////////////////////////////////////////////////////
    // Pattern generator, one process drives the pin, changes after edges
    initial begin
        tmr_pin = 1'b0;
        busy = 1'b0;
        lvl = 1'b0;
        forever begin
            @(posedge core_clk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                lvl = idle_lvl;
                tmr_pin <= lvl;
                repeat (gap) @(posedge core_clk);
                for (int i = 0; i < n_tog; i++) begin
                    lvl = ~lvl;
                    tmr_pin <= lvl;
                    repeat (gap) @(posedge core_clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : tec_pin_src

// [tb/testbench.sv]
/*
 * Self-checking bench for the timer/event counter: APB master tasks,
 * pin partner, integer reference expectations for every result.
 * Assumes tec_top with no wait states and a 20 MHz core_clk.
 */
`timescale 1ns/1ps

module testbench;
    logic core_clk = 1'b0; // 50 ns clock
    logic reset_n = 1'b0; // Active-low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [7:0] paddr = 8'h00; // APB address
    logic [31:0] pwdata = 32'h0000_0000, prdata; // APB data
    logic pready, pslverr, ovf_irq, wake_req; // Design outputs
    logic power_down = 1'b0, tmr_pin; // Power state, pin
    logic go = 1'b0, idle_lvl = 1'b0, busy; // Partner controls
    logic [7:0] n_tog = 8'h00, gap = 8'h03; // Partner pattern
    int error_cnt = 0, samples_checked = 0, ovf_cnt = 0, wake_cnt = 0;
    logic [31:0] rd; // Last read data
    logic er; // Last error flag
    int p, q, k, n, a, b;

    always #25 core_clk = ~core_clk;

    tec_top u_tec_top (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmr_pin(tmr_pin),
        .power_down(power_down), .ovf_irq(ovf_irq), .wake_req(wake_req));

    tec_pin_src u_tec_pin_src (.core_clk(core_clk), .go(go), .idle_lvl(idle_lvl),
        .n_tog(n_tog), .gap(gap), .tmr_pin(tmr_pin), .busy(busy));

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters for interrupt and wake requests
    always @(posedge core_clk) begin
        if (ovf_irq === 1'b1) ovf_cnt <= ovf_cnt + 1;
        if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
    end

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // Bounded wait ran out: count it and close the run
    task automatic timeout_fail;
        error_cnt++;
        $display("MISMATCH t=%0t wait timed out", $time);
        final_report();
    endtask : timeout_fail

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout_fail();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns in this time step
        @(posedge core_clk);
    endtask : apb

    // Read and compare data and error flag
    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp, input logic e);
        apb(1'b0, ad, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask : rdc

    // Edges until the next overflow request, bounded
    task automatic wait_ovf(output int cyc);
        for (cyc = 1; cyc < 3000; cyc++) begin
            @(posedge core_clk);
            if (ovf_irq === 1'b1) return;
        end
        timeout_fail();
    endtask : wait_ovf

    // Run one pin pattern on the partner and wait its end
    task automatic pin_run(input logic il, input int nt, input int gp);
        int i;
        idle_lvl <= il;
        n_tog <= nt[7:0];
        gap <= gp[7:0];
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (i = 0; i < 3000; i++) begin
            @(posedge core_clk);
            if (busy === 1'b0) break;
        end
        if (i == 3000) timeout_fail();
        repeat (6) @(posedge core_clk);
    endtask : pin_run

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(63));
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        // Reset values, unmapped and reserved places
        rdc(8'h04, 32'h0000_0000, 1'b0);
        rdc(8'h08, 32'h0000_0000, 1'b0);
        rdc(8'h00, 32'h0000_0000, 1'b0);
        rdc(8'h0C, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h04, 32'h0000_0030);
        rdc(8'h04, 32'h0000_0010, 1'b0);
        // Idle mode with run set: preload lands, counter stays
        p = $urandom_range(1, 250);
        apb(1'b1, 8'h00, p);
        rdc(8'h00, p, 1'b0);
        rdc(8'h00, p, 1'b0);
        // Timer mode: overflow period per prescale rate, rates 0 to 2
        apb(1'b1, 8'h08, 32'h0000_0001);
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 8'h04, 32'h0000_0000);
            p = $urandom_range(240, 253);
            apb(1'b1, 8'h00, p);
            rdc(8'h00, p, 1'b0);
            apb(1'b1, 8'h04, 32'h90 | r);
            wait_ovf(n);
            wait_ovf(n);
            chk(n, (256 - p) << r);
            q = $urandom_range(240, 254);
            apb(1'b1, 8'h00, q);
            wait_ovf(n);
            wait_ovf(n);
            chk(n, (256 - q) << r);
            apb(1'b1, 8'h04, 32'h80 | r);
            apb(1'b0, 8'h00, 32'h0000_0000);
            a = rd;
            repeat (10) @(posedge core_clk);
            rdc(8'h00, a, 1'b0);
        end
        // Interrupt enable cleared: no request
        apb(1'b1, 8'h08, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_00F0);
        apb(1'b1, 8'h04, 32'h0000_0090);
        a = ovf_cnt;
        repeat (100) @(posedge core_clk);
        chk(ovf_cnt - a, 0);
        // Event counting on each edge polarity, rate ignored
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, 8'h04, 32'h0000_0000);
            apb(1'b1, 8'h00, 32'h0000_0000);
            apb(1'b1, 8'h04, 32'h57 | (e << 3));
            k = $urandom_range(1, 20);
            pin_run(1'b0, 2 * k, $urandom_range(3, 9));
            rdc(8'h00, k, 1'b0);
        end
        chk(wake_cnt, 0);
        // Event overflow during power-down wakes the core
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b1, 8'h08, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_00FE);
        power_down <= 1'b1;
        apb(1'b1, 8'h04, 32'h0000_0050);
        a = ovf_cnt;
        b = wake_cnt;
        pin_run(1'b0, 4, 5);
        chk(ovf_cnt - a, 1);
        chk(wake_cnt - b, 1);
        rdc(8'h00, 32'h0000_00FE, 1'b0);
        power_down <= 1'b0;
        // Pulse width measurement, both polarities
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, 8'h04, 32'h0000_0000);
            pin_run(e == 0, 0, 4);
            apb(1'b1, 8'h00, 32'h0000_0000);
            apb(1'b1, 8'h04, 32'hD0 | (e << 3));
            k = $urandom_range(5, 60);
            pin_run(e == 0, 2, k);
            apb(1'b0, 8'h00, 32'h0000_0000);
            n = rd;
            chk(n >= k - 1 && n <= k + 1, 1);
            rdc(8'h04, 32'hC0 | (e << 3), 1'b0);
        end
        final_report();
    end
endmodule : testbench
